/* File: design/bsc_branch_skip_unit.sv */
// branch/skip unit top: evaluates the condition, updates pc, counts cycles
`timescale 1ns/1ns

// Notes on behaviour
// - register-bit-set skip tests bit b of working register; skips when one
// - io-bit-clear skip tests bit b of io register; skips when zero
// - io-bit-set skip tests bit b of io register; skips when one
// - flag-set branch jumps to pc plus k plus one when flag s is one
// - flag-clear branch jumps to pc plus k plus one when flag s is zero
// - equal branch jumps when zero flag is one
// - not-equal branch jumps when zero flag is zero
// - carry-set branch jumps when carry is one, else falls through
// - carry-clear branch jumps when carry is zero
// - same-or-higher branch behaves exactly as carry-clear branch
// - minus branch jumps on negative one, plus branch on negative zero
// - signed greater-or-equal jumps when negative xor overflow is zero
// - signed less-than jumps when negative xor overflow is one
// - half-carry set and clear branches test the half-carry flag
// - transfer-flag-set branch jumps when transfer flag is one
// - no skip or branch changes any status flag
module bsc_branch_skip_unit
  import bsc_pkg::*;
#(
  parameter int PC_W = BSC_PC_W
)
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire bsc_req_t req_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] flags_in,
  output logic req_ready_out,
  output logic done_out,
  output bsc_res_t res_out,
  output logic [7:0] flags_out
);

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  bsc_state_t state_q;
  bsc_state_t state_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic hit;
  logic is_skip;
  logic is_branch;
  logic accept;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] ofs_ext;
  logic [PC_W-1:0] next_pc;
  logic [1:0] cycles;
  bsc_res_t res_q;
  logic [7:0] flags_q;
  logic done_q;

  // ----------------------------------------------------------------
  // condition evaluation
  // ----------------------------------------------------------------
  bsc_cond_eval u_cond (
    .op_in(req_in.op),
    .sel_in(req_in.sel),
    .operand_in(req_in.operand),
    .flags_in(flags_in),
    .hit_out(hit),
    .is_skip_out(is_skip),
    .is_branch_out(is_branch)
  );

  // ----------------------------------------------------------------
  // target and cycle count
  // ----------------------------------------------------------------
  assign accept = req_valid_in && (state_q == BSC_ST_IDLE) && (is_skip || is_branch);
  assign pc_inc = PC_W'(pc_in + PC_W'(BSC_PC_STEP1));
  assign ofs_ext = {{(PC_W-BSC_OFS_W){req_in.ofs[BSC_OFS_W-1]}}, req_in.ofs};

  always_comb begin
    next_pc = pc_inc;
    cycles = BSC_CYC_ONE;
    if (is_branch && hit) begin
      next_pc = PC_W'(pc_inc + ofs_ext);
      cycles = BSC_CYC_TWO;
    end else if (is_skip && hit) begin
      if (req_in.next_two_word) begin
        next_pc = PC_W'(pc_in + PC_W'(BSC_PC_STEP3));
        cycles = BSC_CYC_THREE;
      end else begin
        next_pc = PC_W'(pc_in + PC_W'(BSC_PC_STEP2));
        cycles = BSC_CYC_TWO;
      end
    end
  end

  // ----------------------------------------------------------------
  // busy state: hold off new requests for the instruction's cycles
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      BSC_ST_IDLE: begin
        if (accept && (cycles != BSC_CYC_ONE)) begin
          state_d = BSC_ST_BUSY;
          cnt_d = 2'(cycles - BSC_CYC_ONE);
        end
      end
      BSC_ST_BUSY: begin
        cnt_d = 2'(cnt_q - 2'h1);
        if (cnt_q == 2'h1) begin
          state_d = BSC_ST_IDLE;
        end
      end
      default: begin
        state_d = BSC_ST_IDLE;
        cnt_d = 2'h0;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= BSC_ST_IDLE;
      cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // result register, loaded when a request is taken
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_q <= '0;
      res_q.pc <= BSC_PC_RESET;
      done_q <= 1'b0;
    end else begin
      done_q <= accept;
      if (accept) begin
        res_q.pc <= next_pc;
        res_q.cycles <= cycles;
        res_q.taken <= hit;
      end
    end
  end

  // flags pass through unchanged
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_q <= BSC_FLAGS_RESET;
    end else if (accept) begin
      flags_q <= flags_in;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready_out = (state_q == BSC_ST_IDLE);
  assign done_out = done_q;
  assign res_out = res_q;
  assign flags_out = flags_q;

endmodule // bsc_branch_skip_unit

/* File: shared/bsc_pkg.sv */
// package: operation codes, flag positions, widths and cycle counts of the branch/skip unit
package bsc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int BSC_PC_W = 16;
  localparam int BSC_OFS_W = 7;

  // ----------------------------------------------------------------
  // processor flag register bit positions
  // ----------------------------------------------------------------
  localparam logic [2:0] BSC_FLAG_C = 3'h0;
  localparam logic [2:0] BSC_FLAG_Z = 3'h1;
  localparam logic [2:0] BSC_FLAG_N = 3'h2;
  localparam logic [2:0] BSC_FLAG_V = 3'h3;
  localparam logic [2:0] BSC_FLAG_S = 3'h4;
  localparam logic [2:0] BSC_FLAG_H = 3'h5;
  localparam logic [2:0] BSC_FLAG_T = 3'h6;
  localparam logic [2:0] BSC_FLAG_I = 3'h7;

  // ----------------------------------------------------------------
  // cycle counts and pc steps
  // ----------------------------------------------------------------
  localparam logic [1:0] BSC_CYC_ONE = 2'h1;
  localparam logic [1:0] BSC_CYC_TWO = 2'h2;
  localparam logic [1:0] BSC_CYC_THREE = 2'h3;
  localparam logic [15:0] BSC_PC_STEP1 = 16'h0001;
  localparam logic [15:0] BSC_PC_STEP2 = 16'h0002;
  localparam logic [15:0] BSC_PC_STEP3 = 16'h0003;
  localparam logic [15:0] BSC_PC_RESET = 16'h0000;
  localparam logic [7:0] BSC_FLAGS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // operations handled by this unit
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    BSC_OP_NONE = 5'b00000,
    BSC_OP_SKIP_REG_BIT_SET = 5'b00001,
    BSC_OP_SKIP_IO_BIT_CLEAR = 5'b00010,
    BSC_OP_SKIP_IO_BIT_SET = 5'b00011,
    BSC_OP_BRANCH_FLAG_SET = 5'b00100,
    BSC_OP_BRANCH_FLAG_CLEAR = 5'b00101,
    BSC_OP_BRANCH_EQUAL = 5'b00110,
    BSC_OP_BRANCH_NOT_EQUAL = 5'b00111,
    BSC_OP_BRANCH_CARRY_SET = 5'b01000,
    BSC_OP_BRANCH_CARRY_CLEAR = 5'b01001,
    BSC_OP_BRANCH_SAME_OR_HIGHER = 5'b01010,
    BSC_OP_BRANCH_MINUS = 5'b01011,
    BSC_OP_BRANCH_PLUS = 5'b01100,
    BSC_OP_BRANCH_SIGNED_GE = 5'b01101,
    BSC_OP_BRANCH_SIGNED_LT = 5'b01110,
    BSC_OP_BRANCH_HALF_CARRY_SET = 5'b01111,
    BSC_OP_BRANCH_HALF_CARRY_CLEAR = 5'b10000,
    BSC_OP_BRANCH_TRANSFER_FLAG_SET = 5'b10001
  } bsc_op_t;

  // request from the decoder
  typedef struct packed {
    bsc_op_t op;
    logic [2:0] sel;                 // bit b or flag s
    logic [BSC_OFS_W-1:0] ofs;       // signed k
    logic [7:0] operand;             // working register or io register value
    logic next_two_word;             // following instruction is two words
  } bsc_req_t;

  // result to fetch
  typedef struct packed {
    logic [BSC_PC_W-1:0] pc;
    logic [1:0] cycles;
    logic taken;
  } bsc_res_t;

  // pc step state machine
  typedef enum logic [1:0] {
    BSC_ST_IDLE = 2'b00,
    BSC_ST_BUSY = 2'b01
  } bsc_state_t;

endpackage

/* File: design/bsc_cond_eval.sv */
// condition evaluator: decides take/skip from flags and operand bit
`timescale 1ns/1ns
module bsc_cond_eval
  import bsc_pkg::*;
(
  input wire bsc_op_t op_in,
  input wire logic [2:0] sel_in,
  input wire logic [7:0] operand_in,
  input wire logic [7:0] flags_in,
  output logic hit_out,
  output logic is_skip_out,
  output logic is_branch_out
);

  // ----------------------------------------------------------------
  // condition decode
  // ----------------------------------------------------------------
  always_comb begin
    hit_out = 1'b0;
    is_skip_out = 1'b0;
    is_branch_out = 1'b1;
    case (op_in)
      BSC_OP_SKIP_REG_BIT_SET: begin
        is_skip_out = 1'b1;
        is_branch_out = 1'b0;
        hit_out = operand_in[sel_in];
      end
      BSC_OP_SKIP_IO_BIT_CLEAR: begin
        is_skip_out = 1'b1;
        is_branch_out = 1'b0;
        hit_out = ~operand_in[sel_in];
      end
      BSC_OP_SKIP_IO_BIT_SET: begin
        is_skip_out = 1'b1;
        is_branch_out = 1'b0;
        hit_out = operand_in[sel_in];
      end
      BSC_OP_BRANCH_FLAG_SET: hit_out = flags_in[sel_in];
      BSC_OP_BRANCH_FLAG_CLEAR: hit_out = ~flags_in[sel_in];
      BSC_OP_BRANCH_EQUAL: hit_out = flags_in[BSC_FLAG_Z];
      BSC_OP_BRANCH_NOT_EQUAL: hit_out = ~flags_in[BSC_FLAG_Z];
      BSC_OP_BRANCH_CARRY_SET: hit_out = flags_in[BSC_FLAG_C];
      BSC_OP_BRANCH_CARRY_CLEAR: hit_out = ~flags_in[BSC_FLAG_C];
      BSC_OP_BRANCH_SAME_OR_HIGHER: hit_out = ~flags_in[BSC_FLAG_C];
      BSC_OP_BRANCH_MINUS: hit_out = flags_in[BSC_FLAG_N];
      BSC_OP_BRANCH_PLUS: hit_out = ~flags_in[BSC_FLAG_N];
      BSC_OP_BRANCH_SIGNED_GE: hit_out = ~(flags_in[BSC_FLAG_N] ^ flags_in[BSC_FLAG_V]);
      BSC_OP_BRANCH_SIGNED_LT: hit_out = flags_in[BSC_FLAG_N] ^ flags_in[BSC_FLAG_V];
      BSC_OP_BRANCH_HALF_CARRY_SET: hit_out = flags_in[BSC_FLAG_H];
      BSC_OP_BRANCH_HALF_CARRY_CLEAR: hit_out = ~flags_in[BSC_FLAG_H];
      BSC_OP_BRANCH_TRANSFER_FLAG_SET: hit_out = flags_in[BSC_FLAG_T];
      default: begin
        is_branch_out = 1'b0;
        hit_out = 1'b0;
      end
    endcase
  end

endmodule // bsc_cond_eval

/* File: bench/bsc_props.sv */
// checker: port-level timing and condition properties of the branch/skip unit
`timescale 1ns/1ns
module bsc_props
  import bsc_pkg::*;
#(
  parameter int PC_W = BSC_PC_W
)
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire bsc_req_t req_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic req_ready_out,
  input wire logic done_out,
  input wire bsc_res_t res_out,
  input wire logic [7:0] flags_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic acc;
  logic bsel;
  // accept strobe and tested operand bit
  assign acc = req_valid_in && req_ready_out && (req_in.op != BSC_OP_NONE)
    && (req_in.op <= BSC_OP_BRANCH_TRANSFER_FLAG_SET);
  assign bsel = req_in.operand[req_in.sel];

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_done; acc |=> done_out; endproperty
  a_done: assert property (p_done) else $error("done missing after accept");
  property p_idle; !acc |=> !done_out; endproperty
  a_idle: assert property (p_idle) else $error("done without accept");
  property p_flags; acc |=> flags_out == $past(flags_in); endproperty
  a_flags: assert property (p_flags) else $error("flags altered");
  property p_miss;
    acc |=> res_out.taken || (res_out.pc == $past(pc_in) + 16'h0001
      && res_out.cycles == BSC_CYC_ONE);
  endproperty
  a_miss: assert property (p_miss) else $error("fall-through wrong");
  property p_eq; acc && req_in.op == BSC_OP_BRANCH_EQUAL |=> res_out.taken == $past(flags_in[1]);
  endproperty
  a_eq: assert property (p_eq) else $error("equal branch wrong");
  property p_ne;
    acc && req_in.op == BSC_OP_BRANCH_NOT_EQUAL |=> res_out.taken != $past(flags_in[1]);
  endproperty
  a_ne: assert property (p_ne) else $error("not-equal branch wrong");
  property p_lt;
    acc && req_in.op == BSC_OP_BRANCH_SIGNED_LT
      |=> res_out.taken == ($past(flags_in[2]) ^ $past(flags_in[3]));
  endproperty
  a_lt: assert property (p_lt) else $error("signed less-than wrong");
  property p_skip_reg_bit_set; acc && req_in.op == BSC_OP_SKIP_REG_BIT_SET |=> res_out.taken == $past(bsel);
  endproperty
  a_skip_reg_bit_set: assert property (p_skip_reg_bit_set) else $error("register bit skip wrong");
  property p_cyc3;
    done_out && res_out.cycles == BSC_CYC_THREE |-> !req_ready_out ##1 !req_ready_out
      ##1 req_ready_out;
  endproperty
  a_cyc3: assert property (p_cyc3) else $error("three-cycle stall wrong");
  property p_cyc2; done_out && res_out.cycles == BSC_CYC_TWO |-> !req_ready_out ##1 req_ready_out;
  endproperty
  a_cyc2: assert property (p_cyc2) else $error("two-cycle stall wrong");

  // main scenarios
  c_three: cover property (done_out && res_out.cycles == BSC_CYC_THREE);
  c_two: cover property (done_out && res_out.cycles == BSC_CYC_TWO);
  c_b2b: cover property (acc ##1 acc);
endmodule // bsc_props

/* File: bench/testbench.sv */
// testbench: random requests checked against a behavioural model
`timescale 1ns/1ns
module testbench;
  import bsc_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic req_valid;
  bsc_req_t req;
  logic [15:0] pc_v;
  logic [7:0] flags;
  logic req_ready;
  logic done;
  bsc_res_t res;
  logic [7:0] flags_o;
  int fails;
  int checked;
  int last_cyc;
  logic [31:0] seed;

  bsc_branch_skip_unit bsc_branch_skip_unit_i (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .req_valid_in(req_valid), .req_in(req), .pc_in(pc_v), .flags_in(flags),
    .req_ready_out(req_ready), .done_out(done), .res_out(res), .flags_out(flags_o));

  // clock at 4 ns period
  always #2 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task check(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd(logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // reference model of condition, target and cycle count
  function automatic bsc_res_t model(bsc_req_t r, logic [15:0] pc, logic [7:0] f);
    bsc_res_t e;
    logic h;
    logic b;
    int k;
    b = r.operand[r.sel];
    k = int'($signed(r.ofs));
    case (r.op)
      BSC_OP_SKIP_REG_BIT_SET, BSC_OP_SKIP_IO_BIT_SET: h = b;
      BSC_OP_SKIP_IO_BIT_CLEAR: h = !b;
      BSC_OP_BRANCH_FLAG_SET: h = f[r.sel];
      BSC_OP_BRANCH_FLAG_CLEAR: h = !f[r.sel];
      BSC_OP_BRANCH_EQUAL: h = f[BSC_FLAG_Z];
      BSC_OP_BRANCH_NOT_EQUAL: h = !f[BSC_FLAG_Z];
      BSC_OP_BRANCH_CARRY_SET: h = f[BSC_FLAG_C];
      BSC_OP_BRANCH_CARRY_CLEAR, BSC_OP_BRANCH_SAME_OR_HIGHER: h = !f[BSC_FLAG_C];
      BSC_OP_BRANCH_MINUS: h = f[BSC_FLAG_N];
      BSC_OP_BRANCH_PLUS: h = !f[BSC_FLAG_N];
      BSC_OP_BRANCH_SIGNED_GE: h = !(f[BSC_FLAG_N] ^ f[BSC_FLAG_V]);
      BSC_OP_BRANCH_SIGNED_LT: h = f[BSC_FLAG_N] ^ f[BSC_FLAG_V];
      BSC_OP_BRANCH_HALF_CARRY_SET: h = f[BSC_FLAG_H];
      BSC_OP_BRANCH_HALF_CARRY_CLEAR: h = !f[BSC_FLAG_H];
      BSC_OP_BRANCH_TRANSFER_FLAG_SET: h = f[BSC_FLAG_T];
      default: h = 1'b0;
    endcase
    e.taken = h;
    if (!h) k = 0;
    if (!h || r.op > BSC_OP_SKIP_IO_BIT_SET) begin
      e.pc = pc + 16'(1 + k);
      e.cycles = h ? 2'h2 : 2'h1;
    end else begin
      e.pc = pc + (r.next_two_word ? 16'h0003 : 16'h0002);
      e.cycles = r.next_two_word ? 2'h3 : 2'h2;
    end
    return e;
  endfunction

  task do_reset();
    req_valid = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(res, 32'h0);
    check(flags_o, 32'h0);
    rst_n = 1'b1;
    last_cyc = 1;
  endtask

  // one request: wait ready, drive, check the answer one cycle later
  task issue(bsc_req_t r);
    int n;
    bsc_res_t e;
    n = 0;
    while (req_ready !== 1'b1) begin
      if (n == 8) begin
        fails++;
        print_verdict();
      end
      req_valid = 1'b0;
      @(negedge sys_clk);
      n++;
    end
    check(n, last_cyc - 1);
    req_valid = 1'b1;
    req = r;
    e = model(r, pc_v, flags);
    @(negedge sys_clk);
    if (r.op == BSC_OP_NONE) begin
      check(done, 32'h0);
      last_cyc = 1;
    end else begin
      check(done, 32'h1);
      check(res, e);
      check(flags_o, flags);
      last_cyc = e.cycles;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    bsc_req_t r;
    sys_clk = 1'b0;
    req = '0;
    pc_v = 16'h0000;
    flags = 8'h00;
    seed = 32'h0000_1aac;
    fails = 0;
    checked = 0;
    do_reset();
    for (int i = 0; i < 360; i++) begin
      if (i == 180) do_reset();
      seed = rnd(seed);
      r.op = bsc_op_t'(5'(i % 18));
      {r.sel, r.ofs, r.operand, r.next_two_word} = seed[18:0];
      if (i % 5 == 0) r.ofs = i[0] ? 7'h40 : 7'h3f;
      seed = rnd(seed);
      pc_v = seed[15:0];
      flags = seed[27:20];
      issue(r);
    end
    req_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
    print_verdict();
  end
endmodule // testbench

bind bsc_branch_skip_unit bsc_props #(.PC_W(PC_W)) bsc_props_i (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .req_valid_in(req_valid_in), .req_in(req_in), .pc_in(pc_in),
  .flags_in(flags_in), .req_ready_out(req_ready_out), .done_out(done_out),
  .res_out(res_out), .flags_out(flags_out));
